/* File: design/acr_fifo.sv */
// Synchronous valid/ready FIFO for output sample pairs
`timescale 1ns/1ps
module acr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    // Ready registered from the next count, so it leaves a flop
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid  = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count    <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

/* File: design/acr_pkg.sv */
// Constants for the converter configuration and test pattern register group
package acr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PAT_W  = 18;

    localparam logic [7:0] OFS_INPUT_CTL   = 8'h11;
    localparam logic [7:0] OFS_FUSE_LOAD   = 8'h13;
    localparam logic [7:0] OFS_PAT_LOW     = 8'h14;
    localparam logic [7:0] OFS_PAT_MID     = 8'h15;
    localparam logic [7:0] OFS_PAT_HIGH    = 8'h16;
    localparam logic [7:0] OFS_FCLK_CTL    = 8'h19;

    localparam logic [7:0] RST_VALUE       = 8'h00;

    // Writable bit masks; all other bits are reserved and held at zero
    localparam logic [7:0] MASK_INPUT_CTL  = 8'h25;
    localparam logic [7:0] MASK_FUSE_LOAD  = 8'h01;
    localparam logic [7:0] MASK_PAT_FULL   = 8'hff;
    localparam logic [7:0] MASK_FCLK_CTL   = 8'h91;

    localparam int BIT_SINGLE_ENDED  = 5;
    localparam int BIT_DELAY_PDN     = 2;
    localparam int BIT_AUTO_ZERO     = 0;
    localparam int BIT_FUSE_LOAD     = 0;
    localparam int BIT_FCLK_SOURCE   = 7;
    localparam int BIT_FCLK_DIVIDE   = 4;
    localparam int BIT_FCLK_STRETCH  = 0;
    localparam int SEL_B_HI          = 7;
    localparam int SEL_B_LO          = 5;
    localparam int SEL_A_HI          = 4;
    localparam int SEL_A_LO          = 2;
    localparam int PAT_HIGH_HI       = 1;

    localparam logic [2:0] PAT_NORMAL   = 3'h0;
    localparam logic [2:0] PAT_RAMP     = 3'h2;
    localparam logic [2:0] PAT_CONSTANT = 3'h3;

    localparam int FIFO_DEPTH = 8;
endpackage

/* File: design/acr_regs.sv */
// Configuration registers and test pattern generator of the converter
//
// Behaviour
// R1: Bit 5 set selects single-ended channel A
// R2: Delay-loop off gives half-period sampling, fastest variant
// R3: Host sets delay-loop off only below 40 MSPS
// R4: Auto-zero polarity inverted on fastest variant
// R5: Host pulses fuse load one then zero
// R6: Fuse load resets earlier register writes
// R7: Constant pattern outputs 18-bit value MSB-aligned
// R8: Ramp increment from custom value per resolution
// R9: Channel B select bits 7-5: normal/ramp/constant
// R10: Channel A select bits 4-2: normal/ramp/constant
// R11: Patterns inserted before mapper, native width, MSB-aligned
// R12: Host sets frame clock bits per mode
// R13: Reserved bits written zero, read zero
// R14: Ramp wraps modulo native width, per sample
`timescale 1ns/1ps
module acr_regs #(
    parameter int  NATIVE_W     = 16,
    parameter bit  FAST_VARIANT = 1'b0,
    parameter int  FIFO_DEPTH   = acr_pkg::FIFO_DEPTH
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [acr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [acr_pkg::DATA_W-1:0] reg_wdata,
    output logic [acr_pkg::DATA_W-1:0]      reg_rdata,
    output logic                            reg_rvalid,
    input  wire logic [NATIVE_W-1:0]       conv_a,
    input  wire logic [NATIVE_W-1:0]       conv_b,
    input  wire logic                      conv_valid,
    output logic                           conv_ready,
    output logic [NATIVE_W-1:0]            sample_a,
    output logic [NATIVE_W-1:0]            sample_b,
    output logic                           sample_valid,
    input  wire logic                      sample_ready,
    output logic                           single_ended_input_sel_a,
    output logic                           delay_loop_power_down,
    output logic                           sampling_half_period,
    output logic                           auto_zero_active,
    output logic                           fuse_mapping_reload,
    output logic                           frame_clock_source,
    output logic                           frame_clock_divide,
    output logic                           frame_clock_stretch
);
    localparam int PW = acr_pkg::PAT_W;

    logic [7:0] input_and_sampling_control;
    logic [7:0] fuse_mapping_load;
    logic [7:0] custom_pattern_low;
    logic [7:0] custom_pattern_mid;
    logic [7:0] pattern_select_and_custom_high;
    logic [7:0] frame_clock_control;
    logic       load_prev;
    logic       fuse_clear;

    logic [PW-1:0]       user_pattern_value;
    logic [2:0]          pattern_select_chan_a;
    logic [2:0]          pattern_select_chan_b;
    logic [NATIVE_W-1:0] pattern_const;
    logic [NATIVE_W-1:0] ramp_step;
    logic [NATIVE_W-1:0] ramp_a;
    logic [NATIVE_W-1:0] ramp_b;
    logic [NATIVE_W-1:0] next_a;
    logic [NATIVE_W-1:0] next_b;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [2*NATIVE_W-1:0] fifo_out_data;
    logic                take;

    // Picks the stream value for one channel from its select code
    function automatic logic [NATIVE_W-1:0] pick(
        input logic [2:0]          sel,
        input logic [NATIVE_W-1:0] conv,
        input logic [NATIVE_W-1:0] ramp,
        input logic [NATIVE_W-1:0] cst
    );
        logic [NATIVE_W-1:0] r;
        r = conv;
        if (sel == acr_pkg::PAT_RAMP) begin                          // [R9] [R10]
            r = ramp;
        end else if (sel == acr_pkg::PAT_CONSTANT) begin
            r = cst;
        end
        return r;
    endfunction

    assign user_pattern_value    = {pattern_select_and_custom_high[acr_pkg::PAT_HIGH_HI:0],
                                    custom_pattern_mid, custom_pattern_low};
    assign pattern_select_chan_a =
        pattern_select_and_custom_high[acr_pkg::SEL_A_HI:acr_pkg::SEL_A_LO];
    assign pattern_select_chan_b =
        pattern_select_and_custom_high[acr_pkg::SEL_B_HI:acr_pkg::SEL_B_LO];
    // Value starts at the MSB; low bits beyond native width are dropped
    assign pattern_const = user_pattern_value[PW-1 -: NATIVE_W];        // [R7] [R11]
    // Increment code is an 18-bit step, scaled down to native width
    assign ramp_step     = user_pattern_value[PW-1 -: NATIVE_W] |
                           NATIVE_W'(user_pattern_value[PW-NATIVE_W-1:0] != '0); // [R8]
    // Fuse load completes on the falling edge of the strobe bit
    assign fuse_clear    = load_prev &&
                           !fuse_mapping_load[acr_pkg::BIT_FUSE_LOAD];  // [R5]

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            load_prev <= 1'b0;
        end else begin
            load_prev <= fuse_mapping_load[acr_pkg::BIT_FUSE_LOAD];
        end
    end

    // Completed fuse load wipes other settings, so program it first
    always_ff @(posedge sys_clk) begin
        if (rst || fuse_clear) begin                                   // [R6]
            input_and_sampling_control     <= acr_pkg::RST_VALUE;
            custom_pattern_low             <= acr_pkg::RST_VALUE;
            custom_pattern_mid             <= acr_pkg::RST_VALUE;
            pattern_select_and_custom_high <= acr_pkg::RST_VALUE;
            frame_clock_control            <= acr_pkg::RST_VALUE;
        end else if (reg_wr) begin
            if (reg_addr == acr_pkg::OFS_INPUT_CTL) begin
                input_and_sampling_control <= reg_wdata & acr_pkg::MASK_INPUT_CTL; // [R13]
            end else if (reg_addr == acr_pkg::OFS_PAT_LOW) begin
                custom_pattern_low <= reg_wdata & acr_pkg::MASK_PAT_FULL;
            end else if (reg_addr == acr_pkg::OFS_PAT_MID) begin
                custom_pattern_mid <= reg_wdata & acr_pkg::MASK_PAT_FULL;
            end else if (reg_addr == acr_pkg::OFS_PAT_HIGH) begin
                pattern_select_and_custom_high <= reg_wdata & acr_pkg::MASK_PAT_FULL;
            end else if (reg_addr == acr_pkg::OFS_FCLK_CTL) begin
                frame_clock_control <= reg_wdata & acr_pkg::MASK_FCLK_CTL; // [R13]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fuse_mapping_load <= acr_pkg::RST_VALUE;
        end else if (reg_wr && reg_addr == acr_pkg::OFS_FUSE_LOAD) begin
            fuse_mapping_load <= reg_wdata & acr_pkg::MASK_FUSE_LOAD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (!reg_rd) begin
                reg_rdata <= reg_rdata;
            end else if (reg_addr == acr_pkg::OFS_INPUT_CTL) begin
                reg_rdata <= input_and_sampling_control;
            end else if (reg_addr == acr_pkg::OFS_FUSE_LOAD) begin
                reg_rdata <= fuse_mapping_load;
            end else if (reg_addr == acr_pkg::OFS_PAT_LOW) begin
                reg_rdata <= custom_pattern_low;
            end else if (reg_addr == acr_pkg::OFS_PAT_MID) begin
                reg_rdata <= custom_pattern_mid;
            end else if (reg_addr == acr_pkg::OFS_PAT_HIGH) begin
                reg_rdata <= pattern_select_and_custom_high;
            end else if (reg_addr == acr_pkg::OFS_FCLK_CTL) begin
                reg_rdata <= frame_clock_control;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    // Control levels and the one-cycle reload pulse; each output registered one cycle after its bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            single_ended_input_sel_a <= 1'b0;
            delay_loop_power_down    <= 1'b0;
            sampling_half_period     <= 1'b0;
            auto_zero_active         <= !FAST_VARIANT;
            fuse_mapping_reload      <= 1'b0;
            frame_clock_source       <= 1'b0;
            frame_clock_divide       <= 1'b0;
            frame_clock_stretch      <= 1'b0;
        end else begin
            single_ended_input_sel_a <=
                input_and_sampling_control[acr_pkg::BIT_SINGLE_ENDED];        // [R1]
            // Loop only exists on the fastest part; slower parts ignore the bit
            delay_loop_power_down <= FAST_VARIANT &&
                input_and_sampling_control[acr_pkg::BIT_DELAY_PDN];           // [R2]
            sampling_half_period  <= FAST_VARIANT &&
                input_and_sampling_control[acr_pkg::BIT_DELAY_PDN];           // [R2]
            auto_zero_active <= FAST_VARIANT ~^
                input_and_sampling_control[acr_pkg::BIT_AUTO_ZERO];           // [R4]
            fuse_mapping_reload <= fuse_clear;
            frame_clock_source  <= frame_clock_control[acr_pkg::BIT_FCLK_SOURCE];
            frame_clock_divide  <= frame_clock_control[acr_pkg::BIT_FCLK_DIVIDE];
            frame_clock_stretch <= frame_clock_control[acr_pkg::BIT_FCLK_STRETCH];
        end
    end

    assign take   = conv_valid && fifo_in_ready;
    assign next_a = pick(pattern_select_chan_a, conv_a, ramp_a, pattern_const);
    assign next_b = pick(pattern_select_chan_b, conv_b, ramp_b, pattern_const);

    // Ramps advance once per accepted sample and wrap at native width
    always_ff @(posedge sys_clk) begin
        if (rst || pattern_select_chan_a != acr_pkg::PAT_RAMP) begin
            ramp_a <= '0;
        end else if (take) begin
            ramp_a <= ramp_a + ramp_step;                                 // [R14]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || pattern_select_chan_b != acr_pkg::PAT_RAMP) begin
            ramp_b <= '0;
        end else if (take) begin
            ramp_b <= ramp_b + ramp_step;                                 // [R14]
        end
    end

    assign conv_ready = fifo_in_ready;

    acr_fifo #(
        .WIDTH (2*NATIVE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_data   ({next_b, next_a}),
        .in_valid  (conv_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (!sample_valid || sample_ready)
    );

    // Output stage register so sample ports come from flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sample_a     <= '0;
            sample_b     <= '0;
            sample_valid <= 1'b0;
        end else if (!sample_valid || sample_ready) begin
            sample_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                sample_a <= fifo_out_data[NATIVE_W-1:0];                  // [R11]
                sample_b <= fifo_out_data[2*NATIVE_W-1:NATIVE_W];
            end
        end
    end
endmodule

/* File: test/acr_chk.sv */
// Port assertions for the register group
`timescale 1ns/1ps
module acr_chk #(
    parameter bit FAST_VARIANT = 1'b0
) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       single_ended_input_sel_a,
    input wire logic       delay_loop_power_down,
    input wire logic       sampling_half_period,
    input wire logic       auto_zero_active,
    input wire logic       fuse_mapping_reload,
    input wire logic       frame_clock_source,
    input wire logic       frame_clock_divide,
    input wire logic       frame_clock_stretch
);
    logic armed;
    logic fall;
    // Reload only when a stored one is cleared
    assign fall = reg_wr && reg_addr == 8'h13 && !reg_wdata[0] && armed;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h13) begin
            armed <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Writes in the clearing cycle are lost, so they are left out
    sequence s_wr(logic [7:0] ofs);
        reg_wr && reg_addr == ofs && !$past(fall) ##1 !reg_wr;
    endsequence
    sequence s_reload;
        fall ##2 fuse_mapping_reload ##1 !fuse_mapping_reload;
    endsequence
    property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer timing");
    property p_unmapped;
        reg_rd && !(reg_addr inside {8'h11, [8'h13:8'h16], 8'h19}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rsvd; reg_rd && reg_addr == 8'h11 |=> (reg_rdata & 8'hda) == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
    property p_input;
        s_wr(8'h11) |=> single_ended_input_sel_a == $past(reg_wdata[5], 2)
            && auto_zero_active == ($past(reg_wdata[0], 2) ^ !FAST_VARIANT)
            && delay_loop_power_down == ($past(reg_wdata[2], 2) && FAST_VARIANT)
            && sampling_half_period == delay_loop_power_down;
    endproperty
    a_input: assert property (p_input) else $error("input control outputs wrong");
    property p_fclk;
        s_wr(8'h19) |=> {frame_clock_source, frame_clock_divide, frame_clock_stretch}
            == {$past(reg_wdata[7], 2), $past(reg_wdata[4], 2), $past(reg_wdata[0], 2)};
    endproperty
    a_fclk: assert property (p_fclk) else $error("frame clock outputs wrong");
    property p_pulse; fall |-> s_reload; endproperty
    a_pulse: assert property (p_pulse) else $error("reload pulse missing");
    property p_cause; fuse_mapping_reload |-> $past(fall, 2); endproperty
    a_cause: assert property (p_cause) else $error("reload without cause");
    property p_clear;
        fuse_mapping_reload |=> !single_ended_input_sel_a && !frame_clock_source
            && !frame_clock_divide && !frame_clock_stretch && auto_zero_active == !FAST_VARIANT;
    endproperty
    a_clear: assert property (p_clear) else $error("reload left settings");
endmodule

/* File: test/acr_stream_partner.sv */
// Converter source and sample sink at the stream ports
`timescale 1ns/1ps
module acr_stream_partner (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   src_en,
    input  wire logic   stall,
    input  wire logic   conv_ready,
    output logic [15:0] conv_a,
    output logic [15:0] conv_b,
    output logic        conv_valid,
    output logic        sample_ready,
    output logic [15:0] sent
);
    logic taken;
    initial {conv_a, conv_b, conv_valid, sample_ready, sent} = '0;
    // Offer held until taken; idle data toggles so stale values never match
    always @(posedge sys_clk) begin
        taken = conv_valid && conv_ready;
        #1;
        sent = rst ? 16'h0000 : sent + taken;
        conv_valid = !rst && (src_en || (conv_valid && !taken));
        conv_a = conv_valid ? sent : ~conv_a;
        conv_b = conv_valid ? ~sent : ~conv_b;
        sample_ready = !stall;
    end
endmodule

/* File: test/test_adc_config_and_test_pattern_regs.sv */
// Bench for the register group and pattern generator
`timescale 1ns/1ps
module test_adc_config_and_test_pattern_regs;
    localparam logic [7:0] OFS [6] = '{8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h19};
    localparam logic [7:0] FC [5] = '{8'h00, 8'h10, 8'h80, 8'h01, 8'hff};
    logic        sys_clk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, src_en = 1'b0, stall = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [15:0] conv_a, conv_b, sample_a, sample_b, sent, a, b, pa, pb;
    logic        reg_rvalid, conv_valid, conv_ready, sample_valid, sample_ready, fuse_mapping_reload;
    logic        single_ended_input_sel_a, delay_loop_power_down, sampling_half_period;
    logic        auto_zero_active, frame_clock_source, frame_clock_divide, frame_clock_stretch;
    logic [2:0]  fclk;
    logic        f_dlp, f_half, f_az;
    int          fails = 0, compares = 0, cycles = 0;
    assign fclk = {frame_clock_source, frame_clock_divide, frame_clock_stretch};
    acr_regs #(.NATIVE_W(16), .FAST_VARIANT(1'b0)) acr_regs_i (.sys_clk, .rst, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .conv_a, .conv_b, .conv_valid, .conv_ready,
        .sample_a, .sample_b, .sample_valid, .sample_ready, .single_ended_input_sel_a,
        .delay_loop_power_down, .sampling_half_period, .auto_zero_active, .fuse_mapping_reload,
        .frame_clock_source, .frame_clock_divide, .frame_clock_stretch);
    acr_stream_partner acr_stream_partner_i (.sys_clk, .rst, .src_en, .stall, .conv_ready,
        .conv_a, .conv_b, .conv_valid, .sample_ready, .sent);
    // Fastest variant shares the register bus; its stream side stays idle
    acr_regs #(.NATIVE_W(16), .FAST_VARIANT(1'b1)) acr_regs_fast_i (.sys_clk, .rst, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(), .reg_rvalid(), .conv_a, .conv_b,
        .conv_valid(1'b0), .conv_ready(), .sample_a(), .sample_b(), .sample_valid(),
        .sample_ready(1'b1), .single_ended_input_sel_a(), .delay_loop_power_down(f_dlp),
        .sampling_half_period(f_half), .auto_zero_active(f_az), .fuse_mapping_reload(),
        .frame_clock_source(), .frame_clock_divide(), .frame_clock_stretch());
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] ad, d, exp);
        reg_addr = ad;
        reg_wdata = d;
        {reg_wr, reg_rd} = {w, !w};
        @(posedge sys_clk) #1;
        {reg_wr, reg_rd} = 2'b00;
        if (!w) chk({reg_rvalid, reg_rdata}, {1'b1, exp});
        @(posedge sys_clk) #1;
    endtask
    // Samples at the edge itself, before the design's updates land
    task automatic grab;
        int n = 0;
        @(posedge sys_clk);
        while (!(sample_valid === 1'b1 && sample_ready === 1'b1) && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        chk(n < 50, 1'b1);
        {a, b} = {sample_a, sample_b};
    endtask
    task automatic run(input logic [7:0] hi, mid, lo, input logic ma, input logic [15:0] ka,
                       input logic ib, mb, input logic [15:0] kb);
        acc(1, 8'h14, lo, 0);
        acc(1, 8'h15, mid, 0);
        acc(1, 8'h16, hi, 0);
        // Samples queued under the previous mode are skipped
        repeat (12) grab;
        {pa, pb} = {a, ib ? ~b : b};
        repeat (4) begin
            grab;
            chk(a, ma ? pa + ka : ka);
            chk(ib ? ~b : b, mb ? pb + kb : kb);
            {pa, pb} = {a, ib ? ~b : b};
        end
        #1;
    endtask
    task automatic stop_test;
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            stop_test;
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        chk({auto_zero_active, single_ended_input_sel_a, conv_ready}, 3'h5);
        chk({f_dlp, f_half, f_az}, 3'h0);
        foreach (OFS[i]) acc(0, OFS[i], 0, 8'h00);
        acc(1, 8'h12, 8'hff, 0);
        acc(0, 8'h12, 0, 8'h00);
        acc(1, 8'h11, 8'hff, 0);
        acc(0, 8'h11, 0, 8'h25);
        chk({single_ended_input_sel_a, auto_zero_active}, 2'b10);
        chk({delay_loop_power_down, sampling_half_period}, 2'b00);
        chk({f_dlp, f_half, f_az}, 3'h7);
        acc(1, 8'h13, 8'hff, 0);
        acc(0, 8'h13, 0, 8'h01);
        foreach (FC[i]) begin
            acc(1, 8'h19, FC[i], 0);
            chk(fclk, {FC[i][7], FC[i][4], FC[i][0]});
        end
        acc(0, 8'h19, 0, 8'h91);
        acc(1, 8'h14, 8'h3c, 0);
        acc(1, 8'h13, 8'h00, 0);
        chk(fuse_mapping_reload, 1'b1);
        @(posedge sys_clk) #1;
        chk({fuse_mapping_reload, single_ended_input_sel_a, fclk, auto_zero_active}, 6'h01);
        chk({f_dlp, f_half, f_az}, 3'h0);
        foreach (OFS[i]) acc(0, OFS[i], 0, 8'h00);
        src_en = 1'b1;
        run(8'h62, 8'h5a, 8'h3c, 1, 16'h0001, 0, 0, 16'h968f);
        run(8'h08, 8'h00, 8'h04, 1, 16'h0001, 1, 1, 16'h0001);
        run(8'h0a, 8'h00, 8'h00, 1, 16'h8000, 1, 1, 16'h0001);
        run(8'h4f, 8'h00, 8'h00, 0, 16'hc000, 0, 1, 16'hc000);
        run(8'h24, 8'h00, 8'h00, 1, 16'h0001, 1, 1, 16'h0001);
        stall = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        chk({conv_ready, sample_valid}, 2'b01);
        {src_en, stall} = 2'b00;
        grab;
        #1;
        pa = a;
        for (int i = 0; i < 12 && sample_valid === 1'b1; i++) begin
            grab;
            #1;
            chk(a, pa + 16'h0001);
            pa = a;
        end
        chk({sample_valid, pa}, {1'b0, sent - 16'h0001});
        rst = 1'b1;
        @(posedge sys_clk) #1;
        rst = 1'b0;
        acc(0, 8'h16, 0, 8'h00);
        stop_test;
    end
endmodule
bind acr_regs acr_chk #(.FAST_VARIANT(FAST_VARIANT)) acr_chk_i (.sys_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .single_ended_input_sel_a,
    .delay_loop_power_down, .sampling_half_period, .auto_zero_active, .fuse_mapping_reload,
    .frame_clock_source, .frame_clock_divide, .frame_clock_stretch);
